// file: logic/eifs_defines.vh
`ifndef EIFS_DEFINES_VH
`define EIFS_DEFINES_VH
// register byte offsets
`define EIFS_OFF_CFG        8'h00
`define EIFS_OFF_SP1        8'h04
`define EIFS_OFF_SP2        8'h08
`define EIFS_OFF_GAIN1      8'h0C
`define EIFS_OFF_GAIN2      8'h10
`define EIFS_OFF_DRIVE      8'h14
`define EIFS_OFF_TUNE       8'h18
`define EIFS_OFF_STATUS     8'h1C
// cfg fields
`define EIFS_CFG_FN_LSB     0
`define EIFS_CFG_FMT_BIT    4
`define EIFS_CFG_SRC_LSB    8
// setpoint source codes
`define EIFS_SRC_DUAL       3'd1
`define EIFS_SRC_RAMP_MIN   3'd2
`define EIFS_SRC_RAMP_HR    3'd3
// function codes
`define EIFS_FN_NONE        4'd0
`define EIFS_FN_SP2         4'd1
`define EIFS_FN_SWAP_GAINS        4'd2
`define EIFS_FN_SPP2        4'd3
`define EIFS_FN_CLR_A1      4'd4
`define EIFS_FN_CLR_A2      4'd5
`define EIFS_FN_CLR_A12     4'd6
`define EIFS_FN_BLANK1      4'd7
`define EIFS_FN_BLANK2      4'd8
`define EIFS_FN_BLANK12     4'd9
`define EIFS_FN_LOCK        4'd10
// reset values
`define EIFS_RST_CFG        32'h0000_0000
`define EIFS_RST_WORD       32'h0000_0000
`define EIFS_RST_HALF       16'h0000
`define EIFS_RST_ADDR       8'h00
`define EIFS_RST_BIT        1'b0
`define EIFS_RST_READY      1'b1
`endif

// file: logic/eifs_top.v
// Overview of operation
// - a config field selects one of eleven event functions, codes 0 to 10
// - code 0 ignores the event, first gains, primary or sourced set point
// - code 1 uses secondary set point while event active
// - code 2 uses second gain set while event active
// - code 3 swaps set point and gain set together while active
// - tuning with second gains selected stores results in second gain set
// - tuning without second gains stores results in first gain set
// - code 4 clears alarm one on activation, re-triggers on release if condition
// - code 5 clears alarm two on activation, re-triggers on release if condition
// - code 6 clears both alarms, re-triggers those still active on release
// - code 7 forces output one drive to zero while active
// - code 8 forces output two drive to zero while active
// - code 9 forces both drives to zero while active
// - blanking codes restore normal drives as soon as event releases
// - code 10 blocks all parameter writes while active
// - second set point is secondary value, or primary plus secondary
// - set point swap honoured only for dual or ramp source selections
// - tuning aborts with error if event change alters set point
`timescale 1ns/100ps
`default_nettype none
`include "eifs_defines.vh"
module eifs_top
(
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        clk_en,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        event_in,
  input  wire [15:0] drive1_in,
  input  wire [15:0] drive2_in,
  input  wire        alarm1_cond,
  input  wire        alarm2_cond,
  input  wire        tune_done,
  input  wire [31:0] tune_result,
  output reg  [15:0] active_setpoint_q,
  output reg  [31:0] active_gains_q,
  output reg  [15:0] output_one_drive_q,
  output reg  [15:0] output_two_drive_q,
  output reg         alarm1_q,
  output reg         alarm2_q,
  output reg         param_lock_q,
  output reg         tune_error_q
);

  // register file
  reg  [31:0] cfg_q;
  reg  [15:0] primary_setpoint_q;
  reg  [15:0] secondary_setpoint_q;
  reg  [31:0] gain1_q;
  reg  [31:0] gain2_q;
  reg         tune_run_q;
  // synchroniser and event history
  reg  [1:0]  sync_q;
  reg         evt_q;
  // bus pipeline: address phase captured for the data phase
  reg         wr_pend_q;
  reg  [7:0]  wr_addr_q;
  reg         rd_pend_q;
  reg  [7:0]  rd_addr_q;
  // set point seen last cycle, for the tuning abort
  reg  [15:0] prev_sp_q;

  wire [3:0]  event_function_select = cfg_q[`EIFS_CFG_FN_LSB+3:`EIFS_CFG_FN_LSB];
  wire        secondary_setpoint_format = cfg_q[`EIFS_CFG_FMT_BIT];
  wire [2:0]  setpoint_source_select = cfg_q[`EIFS_CFG_SRC_LSB+2:`EIFS_CFG_SRC_LSB];

  // evt is the second sync stage, first stage feeds only it
  wire        evt     = sync_q[1];
  wire        evt_on  = evt & ~evt_q;
  wire        evt_off = ~evt & evt_q;

  // set point swap only legal for dual or ramp sources; any other
  // source keeps the primary value whatever the event does
  reg         src_ok;
  always @*
  begin
    case (setpoint_source_select)
      `EIFS_SRC_DUAL:     src_ok = 1'b1;
      `EIFS_SRC_RAMP_MIN: src_ok = 1'b1;
      `EIFS_SRC_RAMP_HR:  src_ok = 1'b1;
      default:            src_ok = 1'b0;
    endcase
  end

  // function decode: exactly one behaviour per code; codes 11 to 15
  // fall into default and behave as code 0
  // cfg is a register, so the decode cannot glitch the outputs
  reg         fn_sp;
  reg         fn_gain;
  reg         clr_a1;
  reg         clr_a2;
  reg         fn_blank1;
  reg         fn_blank2;
  reg         fn_lock;
  always @*
  begin
    fn_sp     = 1'b0;
    fn_gain   = 1'b0;
    clr_a1    = 1'b0;
    clr_a2    = 1'b0;
    fn_blank1 = 1'b0;
    fn_blank2 = 1'b0;
    fn_lock   = 1'b0;
    case (event_function_select)
      `EIFS_FN_NONE:
        fn_sp = 1'b0;
      `EIFS_FN_SP2:
        fn_sp = 1'b1;
      `EIFS_FN_SWAP_GAINS:
        fn_gain = 1'b1;
      `EIFS_FN_SPP2:
      begin
        fn_sp   = 1'b1;
        fn_gain = 1'b1;
      end
      `EIFS_FN_CLR_A1:
        clr_a1 = 1'b1;
      `EIFS_FN_CLR_A2:
        clr_a2 = 1'b1;
      `EIFS_FN_CLR_A12:
      begin
        clr_a1 = 1'b1;
        clr_a2 = 1'b1;
      end
      `EIFS_FN_BLANK1:
        fn_blank1 = 1'b1;
      `EIFS_FN_BLANK2:
        fn_blank2 = 1'b1;
      `EIFS_FN_BLANK12:
      begin
        fn_blank1 = 1'b1;
        fn_blank2 = 1'b1;
      end
      `EIFS_FN_LOCK:
        fn_lock = 1'b1;
      default:
        fn_sp = 1'b0;
    endcase
  end

  // selections qualified by the synced event level
  wire        use_sp2   = evt & fn_sp & src_ok;
  wire        use_gain2 = evt & fn_gain;
  wire        lock      = evt & fn_lock;

  // second set point: absolute or offset from primary; the offset sum
  // wraps at sixteen bits, so the user must keep it in range
  reg  [16:0] sp_sum;
  reg  [15:0] sp2_eff;
  reg  [15:0] sp_sel;
  always @*
  begin
    sp_sum = {1'b0, primary_setpoint_q} + {1'b0, secondary_setpoint_q};
    if (secondary_setpoint_format)
      sp2_eff = sp_sum[15:0];
    else
      sp2_eff = secondary_setpoint_q;
    if (use_sp2)
      sp_sel = sp2_eff;
    else
      sp_sel = primary_setpoint_q;
  end

  // blanking follows the synced level, so release restores at once
  wire        blank1 = evt & fn_blank1;
  wire        blank2 = evt & fn_blank2;

  // address phase accepted only when the bus is ready and the slot
  // carries a real transfer (nonseq or seq)
  wire        addr_ph = hsel & htrans[1] & hready;
  wire        wr_go   = wr_pend_q & ~lock;

  // an event edge that moves the set point spoils a running tune
  wire        sp_bump = (evt != evt_q) & (sp_sel != prev_sp_q);

  // two-stage event synchroniser; the contact moves freely in the field,
  // so nothing but stage two may read stage one
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync_q <= 2'b00;
      evt_q  <= `EIFS_RST_BIT;
    end
    else if (clk_en)
    begin
      sync_q <= {sync_q[0], event_in};
      evt_q  <= evt;
    end
  end

  // ahb-lite slave, zero wait states, always okay; every register
  // answers in one cycle, so no slow register can ever be added here
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= `EIFS_RST_BIT;
      wr_addr_q <= `EIFS_RST_ADDR;
      rd_pend_q <= `EIFS_RST_BIT;
      rd_addr_q <= `EIFS_RST_ADDR;
      hreadyout <= `EIFS_RST_READY;
      hresp     <= `EIFS_RST_BIT;
    end
    else if (clk_en)
    begin
      wr_pend_q <= addr_ph & hwrite;
      rd_pend_q <= addr_ph & ~hwrite;
      if (addr_ph)
      begin
        wr_addr_q <= haddr[7:0];
        rd_addr_q <= haddr[7:0];
      end
    end
  end

  // read data registered at address phase; it stands until the next
  // read, so a master may take it late
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= `EIFS_RST_WORD;
    else if (clk_en && addr_ph && !hwrite)
    begin
      case (haddr[7:0])
        `EIFS_OFF_CFG:    hrdata <= cfg_q;
        `EIFS_OFF_SP1:    hrdata <= {16'h0000, primary_setpoint_q};
        `EIFS_OFF_SP2:    hrdata <= {16'h0000, secondary_setpoint_q};
        `EIFS_OFF_GAIN1:  hrdata <= gain1_q;
        `EIFS_OFF_GAIN2:  hrdata <= gain2_q;
        `EIFS_OFF_DRIVE:  hrdata <= {output_two_drive_q, output_one_drive_q};
        `EIFS_OFF_TUNE:   hrdata <= {31'h0000_0000, tune_run_q};
        `EIFS_OFF_STATUS: hrdata <= {26'h000_0000,
                                     tune_error_q,
                                     param_lock_q,
                                     alarm2_q,
                                     alarm1_q,
                                     use_gain2,
                                     evt};
        default:          hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // parameter writes, blocked while locked; tuning stores gains
  // a locked write still gets okay, software must read back to see it
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_q                <= `EIFS_RST_CFG;
      primary_setpoint_q   <= `EIFS_RST_HALF;
      secondary_setpoint_q <= `EIFS_RST_HALF;
      gain1_q              <= `EIFS_RST_WORD;
      gain2_q              <= `EIFS_RST_WORD;
      tune_run_q           <= `EIFS_RST_BIT;
    end
    else if (clk_en)
    begin
      if (wr_go)
      begin
        // only the low sixteen bits of set point words are kept
        case (wr_addr_q)
          `EIFS_OFF_CFG:   cfg_q <= {20'h0_0000, hwdata[11:0]};
          `EIFS_OFF_SP1:   primary_setpoint_q <= hwdata[15:0];
          `EIFS_OFF_SP2:   secondary_setpoint_q <= hwdata[15:0];
          `EIFS_OFF_GAIN1: gain1_q <= hwdata;
          `EIFS_OFF_GAIN2: gain2_q <= hwdata;
          `EIFS_OFF_TUNE:  tune_run_q <= hwdata[0];
          // drive, status and unmapped offsets change nothing here; a status write with bit 5 set clears tune_error_q below
          default:         tune_run_q <= tune_run_q;
        endcase
      end
      // tuning completion wins over a same-cycle write
      if (tune_run_q && tune_done)
      begin
        tune_run_q <= 1'b0;
        if (use_gain2)
          gain2_q <= tune_result;
        else
          gain1_q <= tune_result;
      end
      else if (tune_run_q && sp_bump)
        tune_run_q <= 1'b0;
    end
  end

  // control outputs, alarms and tuning error; drives are registered
  // here, so blanking costs one cycle on top of the synchroniser
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      // outputs rest at zero so drives and alarms start inactive
      active_setpoint_q  <= `EIFS_RST_HALF;
      active_gains_q     <= `EIFS_RST_WORD;
      output_one_drive_q <= `EIFS_RST_HALF;
      output_two_drive_q <= `EIFS_RST_HALF;
      alarm1_q           <= `EIFS_RST_BIT;
      alarm2_q           <= `EIFS_RST_BIT;
      param_lock_q       <= `EIFS_RST_BIT;
      tune_error_q       <= `EIFS_RST_BIT;
      prev_sp_q          <= `EIFS_RST_HALF;
    end
    else if (clk_en)
    begin
      prev_sp_q          <= sp_sel;
      active_setpoint_q  <= sp_sel;
      active_gains_q     <= use_gain2 ? gain2_q : gain1_q;
      output_one_drive_q <= blank1 ? 16'h0000 : drive1_in;
      output_two_drive_q <= blank2 ? 16'h0000 : drive2_in;
      param_lock_q       <= lock;
      // clear on activation; re-trigger from condition on release
      // the clear acts on the activating edge only; a condition present
      // while the event is held does not re-arm the alarm until release
      if (evt_on && clr_a1)
        alarm1_q <= 1'b0;
      else if (alarm1_cond && !(evt && clr_a1))
        alarm1_q <= 1'b1;
      if (evt_on && clr_a2)
        alarm2_q <= 1'b0;
      else if (alarm2_cond && !(evt && clr_a2))
        alarm2_q <= 1'b1;
      // error set wins over software clear; the flag is sticky so a
      // short abort is never missed by a slow poll
      if (tune_run_q && !tune_done && sp_bump)
        tune_error_q <= 1'b1;
      else if (wr_go && wr_addr_q == `EIFS_OFF_STATUS && hwdata[5])
        tune_error_q <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: tb/eifs_switch_model.sv
`timescale 1ns/100ps
`default_nettype none
module eifs_switch_model
(
  input  wire logic hclk,
  input  wire logic closed,
  output logic      event_in
);
  // contact moves just after an edge, like a timer relay; no bounce modelled
  always @(posedge hclk)
    event_in <= closed;
endmodule
`default_nettype wire

// file: tb/eifs_top_sva.sv
`timescale 1ns/100ps
`default_nettype none
module eifs_top_sva
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        event_in,
  input wire logic [15:0] drive1_in,
  input wire logic [15:0] drive2_in,
  input wire logic        alarm1_cond,
  input wire logic        alarm2_cond,
  input wire logic [15:0] output_one_drive_q,
  input wire logic [15:0] output_two_drive_q,
  input wire logic        alarm1_q,
  input wire logic        alarm2_q,
  input wire logic        param_lock_q
);
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // a drive is either passed through or blanked, never altered
  chk_one_pass_zero:
    assert property (output_one_drive_q == 16'h0000 || output_one_drive_q == $past(drive1_in)) else $error("drive one bad");
  chk_two_pass_zero:
    assert property (output_two_drive_q == 16'h0000 || output_two_drive_q == $past(drive2_in)) else $error("drive two bad");
  // event seen low three edges back: no blanking may remain
  chk_one_restored:
    assert property ($past(hresetn, 3) && !$past(event_in, 3) |-> output_one_drive_q == $past(drive1_in))
    else $error("drive one not restored");
  chk_two_restored:
    assert property ($past(hresetn, 3) && !$past(event_in, 3) |-> output_two_drive_q == $past(drive2_in))
    else $error("drive two not restored");
  chk_lock_cause:
    assert property (param_lock_q |-> $past(event_in, 3)) else $error("lock without event");
  // two sync stages: a new event cannot reach the lock for two edges
  chk_lock_synced:
    assert property (!event_in [*3] ##1 $rose(event_in) |-> ##1 !param_lock_q ##1 !param_lock_q)
    else $error("event not synchronised");
  chk_alarm_one_set:
    assert property ((alarm1_cond && !event_in) [*5] |-> alarm1_q) else $error("alarm one missing");
  chk_alarm_two_set:
    assert property ((alarm2_cond && !event_in) [*5] |-> alarm2_q) else $error("alarm two missing");
  cover property ($rose(param_lock_q));
  cover property ($fell(alarm1_q));
  cover property ($fell(output_two_drive_q != 16'h0000));
endmodule
bind eifs_top eifs_top_sva chk_i
(
  .hclk, .hresetn, .event_in, .drive1_in, .drive2_in, .alarm1_cond, .alarm2_cond,
  .output_one_drive_q, .output_two_drive_q, .alarm1_q, .alarm2_q, .param_lock_q
);
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "eifs_defines.vh"
module testbench;
  logic        hclk = 0;
  logic        hresetn = 0;
  logic        hsel = 0;
  logic [31:0] haddr = 0;
  logic [1:0]  htrans = 0;
  logic        hwrite = 0;
  logic [31:0] hwdata = 0;
  logic        closed = 0;
  logic        alarm1_cond = 0;
  logic        alarm2_cond = 0;
  logic        tune_done = 0;
  logic [31:0] tune_result = 0;
  logic [31:0] rd;
  logic        event_in;
  logic [31:0] hrdata;
  logic [31:0] gains;
  logic        hreadyout;
  logic [15:0] sp;
  logic [15:0] o1;
  logic [15:0] o2;
  logic        al1;
  logic        al2;
  logic        lock;
  logic        err;
  logic        resp;
  logic        ce = 1;
  logic [15:0] d1 = 16'h1234;
  logic [15:0] d2 = 16'h5678;
  int          failures = 0;
  int          num_checks = 0;
  int          cyc = 0;
  always #10 hclk = ~hclk;
  eifs_switch_model sw (.hclk, .closed, .event_in);
  // drives come from bench registers so pass-through is seen to follow them
  eifs_top uut
  (
    .hclk, .hresetn, .clk_en(ce), .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp(resp), .event_in, .drive1_in(d1),
    .drive2_in(d2), .alarm1_cond, .alarm2_cond, .tune_done, .tune_result,
    .active_setpoint_q(sp), .active_gains_q(gains), .output_one_drive_q(o1), .output_two_drive_q(o2),
    .alarm1_q(al1), .alarm2_q(al2), .param_lock_q(lock), .tune_error_q(err)
  );
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one single transfer; read data taken at the data-phase edge
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk(32'(resp), 32'h0000_0000);
  endtask
  // contact edge plus two sync stages plus output register
  task automatic evt(input logic v);
    closed <= v;
    repeat (6) @(posedge hclk);
  endtask
  task automatic tune(input logic [31:0] v);
    ahb(1, `EIFS_OFF_TUNE, 32'h0000_0001);
    tune_done <= 1;
    tune_result <= v;
    @(posedge hclk);
    tune_done <= 0;
    repeat (2) @(posedge hclk);
  endtask
  task automatic t_setpoint;
    ahb(0, 8'h40, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    ahb(1, `EIFS_OFF_SP1, 32'h0000_0100);
    ahb(1, `EIFS_OFF_SP2, 32'h0000_0020);
    ahb(1, `EIFS_OFF_CFG, 32'h0000_0101);
    evt(1);
    chk(32'(sp), 32'h0000_0020);
    ahb(1, `EIFS_OFF_CFG, 32'h0000_0111);
    repeat (2) @(posedge hclk);
    chk(32'(sp), 32'h0000_0120);
    ahb(1, `EIFS_OFF_CFG, 32'h0000_0001);
    repeat (2) @(posedge hclk);
    chk(32'(sp), 32'h0000_0100);
    ahb(1, `EIFS_OFF_CFG, 32'h0000_0101);
    evt(0);
    ahb(1, `EIFS_OFF_TUNE, 32'h0000_0001);
    evt(1);
    chk(32'(err), 32'h0000_0001);
    evt(0);
  endtask
  task automatic t_gains;
    ahb(1, `EIFS_OFF_GAIN1, 32'h1111_1111);
    ahb(1, `EIFS_OFF_GAIN2, 32'h2222_2222);
    ahb(1, `EIFS_OFF_CFG, 32'h0000_0002);
    evt(1);
    chk(gains, 32'h2222_2222);
    tune(32'hABCD_0001);
    ahb(0, `EIFS_OFF_GAIN2, 32'h0000_0000);
    chk(rd, 32'hABCD_0001);
    evt(0);
    tune(32'h5555_0002);
    ahb(0, `EIFS_OFF_GAIN1, 32'h0000_0000);
    chk(rd, 32'h5555_0002);
  endtask
  // codes 7, 8, 9 then 0, which must ignore the event
  task automatic t_blank;
    for (int f = 7; f < 11; f++)
    begin
      d1 <= d1 ^ 16'h00FF;
      d2 <= d2 ^ 16'hFF00;
      ahb(1, `EIFS_OFF_CFG, 32'(f % 10));
      evt(1);
      chk(32'(o1), (f == 7 || f == 9) ? 32'h0000_0000 : 32'(d1));
      chk(32'(o2), (f == 8 || f == 9) ? 32'h0000_0000 : 32'(d2));
      evt(0);
      chk({o2, o1}, {d2, d1});
    end
  endtask
  // clock enable low freezes the synchroniser; lock code still set
  task automatic t_freeze;
    ce <= 0;
    evt(1);
    chk(32'(lock), 32'h0000_0000);
    ce <= 1;
    repeat (4) @(posedge hclk);
    chk(32'(lock), 32'h0000_0001);
    evt(0);
  endtask
  task automatic t_alarm;
    alarm1_cond <= 1;
    alarm2_cond <= 1;
    for (int f = 4; f < 7; f++)
    begin
      ahb(1, `EIFS_OFF_CFG, 32'(f));
      evt(1);
      chk(32'({al2, al1}), 32'({f == 4, f == 5}));
      evt(0);
      chk(32'({al2, al1}), 32'h0000_0003);
    end
  endtask
  task automatic t_lock;
    ahb(1, `EIFS_OFF_CFG, 32'h0000_000A);
    evt(1);
    ahb(1, `EIFS_OFF_SP1, 32'h0000_0777);
    ahb(0, `EIFS_OFF_SP1, 32'h0000_0000);
    chk(rd, 32'h0000_0100);
    evt(0);
    ahb(1, `EIFS_OFF_SP1, 32'h0000_0777);
    ahb(0, `EIFS_OFF_SP1, 32'h0000_0000);
    chk(rd, 32'h0000_0777);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1;
    t_setpoint();
    t_gains();
    t_blank();
    t_alarm();
    t_lock();
    t_freeze();
    tally_and_finish();
  end
endmodule
`default_nettype wire
